// ---- logic/host_slave_port.sv ----
`timescale 1ns/1ps
module host_slave_port
  import host_port_pkg::*;
(
  input  wire logic                ref_clk,              // 100 MHz clock.
  input  wire logic                reset,                // Synchronous, high.
  input  wire logic                clk_en,               // Freezes all state when low.
  input  wire logic [`AD_W-1:0]    host_ad_in,           // Muxed address/data in.
  output logic [`AD_W-1:0]         host_ad_out,          // Read data out.
  output logic                     host_ad_oe,           // High while driving data.
  input  wire logic                host_latch_enable_in, // Address phase.
  input  wire logic                host_write_strobe,    // Write strobe, high active.
  input  wire logic                host_read_strobe,     // Read strobe, high active.
  input  wire logic                host_memory_select,   // Memory space select.
  input  wire logic                host_io_select,       // I/O space select.
  input  wire logic                ack_polarity_pin,     // Strap, 1 = high active.
  input  wire logic                host_ack_in,          // Ack pin level, strap.
  output logic                     host_ack_out,         // Ack / ready drive.
  output logic                     host_ack_oe,          // High while driving ack.
  input  wire logic                cfg_wr,               // Write port_config_reg.
  input  wire logic                page_wr,              // Write target_page_reg.
  input  wire logic [7:0]          reg_wdata,            // Register write data.
  output logic [7:0]               port_config_reg,      // Config read-back.
  output logic                     address_cycle_mode,   // 1 = address-cycle mode.
  input  wire logic [`HOST_DMA_PRIO-1:0] peer_req,       // Higher priority DMA.
  output logic                     dma_req,              // Access on DMA bus.
  output dma_cmd_type              dma_cmd,              // Access details.
  input  wire logic                dma_done,             // Access finished.
  input  wire logic [`WORD_W-1:0]  dma_rdata,            // Read data.
  output logic [3:0]               mem_sel,              // One-hot space select.
  output logic                     core_steal            // Core loses a cycle.
);
  import host_port_pkg::*;

  typedef struct packed {
    phase_type          phase;   // Ack state.
    logic               pol;     // Latched polarity.
    logic [7:0]         cfg;     // Config storage.
    logic [`PAGE_W-1:0] page;    // Page register.
    logic [`WORD_W-1:0] addr;    // Target word address.
    logic               io;      // I/O space latched.
    logic               acc;     // Address-cycle mode seen.
    logic [1:0]         idx;     // Unit within word.
    logic [`WORD_W-1:0] asmb;    // Write being assembled.
    logic [`WORD_W-1:0] rbuf;    // Read buffer.
    logic               rbuf_v;  // Read buffer valid.
    logic               rd_want; // Read fetch wanted.
    logic               busy;    // DMA access in flight.
    dma_cmd_type        cmd;     // Access on the bus.
    logic               ack;     // Logical acknowledge.
    logic               ack_pin; // Ack pin level.
    logic               ack_oe;  // Ack pin enable.
    logic [`AD_W-1:0]   ad_out;  // Data driven.
    logic               ad_oe;   // Data enable.
    logic               steal;   // Core steal pulse.
    logic [3:0]         sel;     // Memory selects.
  } state_type;

  state_type    s, n;      // State and next value.
  logic         push;      // Offer posted write.
  logic         room;      // FIFO has room.
  logic         pop;       // Take posted write.
  logic         wvalid;    // Posted write waiting.
  wr_entry_type wentry;    // Entry offered.
  wr_entry_type whead;     // Oldest entry.
  logic         selected;  // Either chip select.
  logic         strobe;    // Data strobe.
  logic         wr_busy;   // A write is still in progress.
  logic         last;      // Current unit ends word.
  logic [1:0]   units;     // Units per word, minus one.

  // Picks the space of a word address.
  function automatic space_type decode(input logic io, input logic [`WORD_W-1:0] a);
    if (io) return SP_IO;
    if (a[`WORD_W-1 -: `PAGE_W] >= `BOOT_PAGE_BASE) return SP_BOOT;
    if (a[`AD_W-1:0] < `INT_MEM_TOP) return SP_INT;
    return SP_EXT;
  endfunction

  // Bit offset of a unit within a word.
  function automatic logic [5:0] unit_ofs(input logic [1:0] i, input logic w16);
    return w16 ? {i, 4'h0} : {1'b0, i, 3'h0};
  endfunction

  // Merges one host unit into the assembly word.
  function automatic logic [`WORD_W-1:0] merge(input logic [`WORD_W-1:0] w,
      input logic [`AD_W-1:0] d, input logic [1:0] i, input logic w16);
    logic [47:0] t;
    logic [47:0] m;
    t = {32'h0, (w16 ? d : {8'h00, d[7:0]})} << unit_ofs(i, w16);
    m = {32'h0, (w16 ? 16'hffff : 16'h00ff)} << unit_ofs(i, w16);
    return (w & ~m[`WORD_W-1:0]) | t[`WORD_W-1:0];
  endfunction

  // Selects one host unit out of the read buffer.
  function automatic logic [`AD_W-1:0] unit_of(input logic [`WORD_W-1:0] w,
      input logic [1:0] i, input logic w16);
    logic [47:0] t;
    t = {24'h0, w} >> unit_ofs(i, w16);
    return w16 ? t[`AD_W-1:0] : {8'h00, t[7:0]};
  endfunction

  assign selected = host_memory_select | host_io_select;
  assign strobe   = selected & (host_read_strobe | host_write_strobe) & ~host_latch_enable_in;
  assign wr_busy  = wvalid | (s.busy & s.cmd.we);
  assign units    = (s.cfg[`CFG_UNITS_LSB +: 2] == 2'h0) ? 2'h0
                    : s.cfg[`CFG_UNITS_LSB +: 2] - 2'h1;
  assign last     = s.idx >= units;
  assign wentry   = '{io: s.io, addr: s.addr, data: merge(s.asmb, host_ad_in, s.idx,
                      s.cfg[`CFG_W16_BIT])};

  // Posted writes queue here so the host does not wait on the DMA bus.
  host_port_fifo #(.W($bits(wr_entry_type)), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .in_valid  (push),
    .in_ready  (room),
    .in_data   (wentry),
    .out_valid (wvalid),
    .out_ready (pop),
    .out_data  (whead)
  );

  // Host side, DMA side and acknowledge in one next-state process.
  always_comb begin
    n       = s;
    push    = 1'b0;
    pop     = 1'b0;
    n.steal = 1'b0;
    // Address phase: latch alone, or latch with write strobe (address cycle).
    if (selected && host_latch_enable_in) begin
      n.addr    = {s.page, host_ad_in};
      n.io      = host_io_select;
      n.acc     = host_write_strobe;
      n.idx     = 2'h0;
      n.rbuf_v  = 1'b0; // A new address voids a buffered prefetch, not one still in flight.
      n.rd_want = 1'b0;
      if (host_write_strobe) n.phase = PH_HOLD;
    end else if (s.phase != PH_HOLD && strobe) begin
      n.phase = PH_WAIT;
      if (host_write_strobe) begin
        if (!last) begin
          // Middle unit of a write: store and acknowledge at once.
          n.asmb  = wentry.data;
          n.idx   = s.idx + 2'h1;
          n.phase = PH_HOLD;
        end else if (room && !(s.busy && s.cmd.we)) begin
          push    = 1'b1;
          n.asmb  = '0;
          n.idx   = 2'h0;
          n.addr  = s.addr + 24'h000001;
          n.phase = PH_HOLD;
        end
      end else if (s.idx != 2'h0 || (s.rbuf_v && !wr_busy)) begin
        // Read unit: the first waits for data, the rest come from the buffer.
        n.ad_out = unit_of(s.rbuf, s.idx, s.cfg[`CFG_W16_BIT]);
        n.ad_oe  = 1'b1;
        n.phase  = PH_HOLD;
        n.idx    = last ? 2'h0 : s.idx + 2'h1;
        if (last) begin
          n.rbuf_v  = 1'b0;
          n.addr    = s.addr + 24'h000001;
          n.rd_want = 1'b1; // Prefetch the next word.
        end
      end else if (!s.rbuf_v) begin
        n.rd_want = 1'b1;
      end
    end else if (s.phase == PH_HOLD && !(selected && (host_read_strobe || host_write_strobe))) begin
      n.phase = PH_IDLE;
      n.ad_oe = 1'b0;
    end
    // DMA bus: posted writes go first so reads never pass them.
    if (s.busy && dma_done) begin
      n.busy = 1'b0;
      if (!s.cmd.we) begin
        n.rbuf   = dma_rdata;
        n.rbuf_v = ~n.rd_want | s.rd_want;
      end
    end else if (!s.busy && peer_req == '0 && (wvalid || (s.rd_want && !s.rbuf_v))) begin
      n.busy = 1'b1;
      if (wvalid) begin
        pop   = 1'b1;
        n.cmd = '{we: 1'b1, space: decode(whead.io, whead.addr), addr: whead.addr,
                  data: whead.data};
      end else begin
        n.rd_want = 1'b0;
        n.cmd     = '{we: 1'b0, space: decode(s.io, s.addr), addr: s.addr,
                      data: '0};
      end
      n.sel   = 4'h1 << n.cmd.space;
      n.steal = n.cmd.space == SP_INT;
    end
    // Register writes; polarity stays read-only.
    if (cfg_wr) n.cfg = {reg_wdata[7:6], 1'b0, reg_wdata[4:0]};
    if (page_wr) n.page = reg_wdata;
    // Mode bits are not used: ack is active only in PH_HOLD while selected, else idle.
    n.ack     = n.phase == PH_HOLD && selected;
    n.ack_oe  = 1'b1;
    n.ack_pin = n.ack ~^ s.pol;
    if (reset) begin
      n        = '0;
      n.pol    = ack_polarity_pin;
      n.cfg    = `CFG_RESET;
      n.cfg[`CFG_READY_BIT] = ack_polarity_pin ~^ host_ack_in;
      n.page   = `PAGE_RESET;
      n.ack_pin = ~ack_polarity_pin;
      push     = 1'b0;
      pop      = 1'b0;
    end
  end

  // One register stage holds all state.
  always_ff @(posedge ref_clk) begin
    if (reset || clk_en) s <= n;
  end

  assign host_ad_out        = s.ad_out;
  assign host_ad_oe         = s.ad_oe;
  assign host_ack_out       = s.ack_pin;
  assign host_ack_oe        = s.ack_oe;
  assign port_config_reg    = {s.cfg[7:6], s.pol, s.cfg[4:0]};
  assign address_cycle_mode = s.acc;
  assign dma_req            = s.busy;
  assign dma_cmd            = s.cmd;
  assign mem_sel            = s.sel;
  assign core_steal         = s.steal;
endmodule

// ---- logic/host_port_params.svh ----
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH
// Notes on behaviour
// - Port is a slave to the host only.
// - Muxed address/data, 8/16-bit, strobed, unclocked host.
// - Internal memory access steals one core cycle.
// - External memory access goes through external interface.
// - Port increments the target address itself.
// - Latch or address-cycle mode detected from pins.
// - Acknowledge polarity caught at reset, read-only.
// - Read completes only with data, no write busy.
// - Write completes only if buffer room, no write busy.
// - Two-bit acknowledge mode field, writable later.
// - Equal strap levels give Ready, else ACK mode.
// - ACK mode: acknowledge until strobe is removed.
// - Ready mode: ready drops to insert waits; the port drives ack the same way in both modes.
// - Every address cycle is acknowledged at once.
// - Device decodes address into memory selects.
// - Up to three accesses merge into one word.
// - Middle units acknowledged at once, others after.
// - Host DMA arbitrates at priority 10 of 12.
`define AD_W            16
`define WORD_W          24
`define PAGE_W          8
`define FIFO_DEPTH      32
`define CFG_W16_BIT     0
`define CFG_UNITS_LSB   1
`define CFG_POL_BIT     5
`define CFG_READY_BIT   6
`define CFG_MODE_HI_BIT 7
`define CFG_RESET       8'h06
`define PAGE_RESET      8'h00
`define HOST_DMA_PRIO   10
`define BOOT_PAGE_BASE  8'h80
`define INT_MEM_TOP     16'h8000
`endif

// ---- logic/host_port_pkg.sv ----
`include "host_port_params.svh"
package host_port_pkg;
  // Ack state machine: idle, waiting on buffers, holding acknowledge.
  typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_WAIT = 2'b01, PH_HOLD = 2'b11} phase_type;
  // Target spaces, one memory select each.
  typedef enum logic [1:0] {SP_INT = 2'b00, SP_EXT = 2'b01, SP_BOOT = 2'b10, SP_IO = 2'b11} space_type;
  // One posted write waiting for the DMA bus.
  typedef struct packed {
    logic                 io;
    logic [`WORD_W-1:0]   addr;
    logic [`WORD_W-1:0]   data;
  } wr_entry_type;
  // One DMA bus access.
  typedef struct packed {
    logic                 we;
    space_type            space;
    logic [`WORD_W-1:0]   addr;
    logic [`WORD_W-1:0]   data;
  } dma_cmd_type;
endpackage

// ---- logic/host_port_fifo.sv ----
`timescale 1ns/1ps
module host_port_fifo #(
  parameter int W     = 49,
  parameter int DEPTH = 32
) (
  input  wire logic         ref_clk,   // Clock.
  input  wire logic         reset,     // Synchronous reset.
  input  wire logic         clk_en,    // Freezes state when low.
  input  wire logic         in_valid,  // Writer offers a word.
  output logic              in_ready,  // Room for a word.
  input  wire logic [W-1:0] in_data,   // Word written.
  output logic              out_valid, // A word is held.
  input  wire logic         out_ready, // Reader takes the word.
  output logic [W-1:0]      out_data   // Oldest word.
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } ptr_type;
  ptr_type       s, n;          // Pointer state and its next value.
  logic [W-1:0]  mem [DEPTH];   // Storage, no reset needed.
  logic          push, pop;     // Accepted handshakes.

  assign in_ready  = s.cnt != (AW+1)'(DEPTH);
  assign out_valid = s.cnt != '0;
  assign out_data  = mem[s.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointers wrap naturally since the depth is a power of two.
  always_comb begin
    n = s;
    if (push) n.wp = s.wp + 1'b1;
    if (pop) n.rp = s.rp + 1'b1;
    n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (reset) n = '0;
  end

  always_ff @(posedge ref_clk) begin
    if (reset || clk_en) s <= n;
    if (clk_en && push) mem[s.wp] <= in_data;
  end
endmodule

// ---- verif/host_slave_port_chk.sv ----
`timescale 1ns/1ps
module host_slave_port_chk
  import host_port_pkg::*;
(
  input wire logic        ref_clk,              // Clock.
  input wire logic        reset,                // Reset.
  input wire logic        host_latch_enable_in, // Address phase.
  input wire logic        host_write_strobe,    // Write strobe.
  input wire logic        host_read_strobe,     // Read strobe.
  input wire logic        host_memory_select,   // Memory select.
  input wire logic        host_io_select,       // I/O select.
  input wire logic        host_ack_out,         // Acknowledge.
  input wire logic        cfg_wr,               // Config write.
  input wire logic [7:0]  reg_wdata,            // Write data.
  input wire logic [7:0]  port_config_reg,      // Config.
  input wire logic        address_cycle_mode,   // Mode seen.
  input wire logic [9:0]  peer_req,             // Peer requests.
  input wire logic        dma_req,              // Request.
  input wire dma_cmd_type dma_cmd,              // Access.
  input wire logic        dma_done,             // Finished.
  input wire logic [3:0]  mem_sel,              // Space.
  input wire logic        core_steal            // Core cycle.
);
  logic sel; // Either chip select.
  assign sel = host_memory_select || host_io_select;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // Three quiet cycles leave room for the one-cycle hold after a strobe ends.
  chk_ack_idle: assert property (!(sel && (host_write_strobe || host_read_strobe)) [*3]
    |-> host_ack_out == !port_config_reg[5]) else $error("ack active while idle");
  chk_addr_cycle: assert property (sel && host_latch_enable_in && host_write_strobe
    |=> host_ack_out == port_config_reg[5] && address_cycle_mode) else $error("address cycle");
  chk_pol_kept: assert property (cfg_wr |=> $stable(port_config_reg[5]))
    else $error("polarity bit written");
  chk_mode_write: assert property (cfg_wr |=> port_config_reg[7:6] == $past(reg_wdata[7:6]))
    else $error("mode bits not written");
  chk_steal_int: assert property (core_steal |-> dma_req && mem_sel == 4'b0001)
    else $error("steal outside internal access");
  chk_ext_free: assert property ($rose(dma_req) && dma_cmd.space != SP_INT |-> !core_steal)
    else $error("steal on external access");
  chk_peer_wait: assert property (peer_req != 10'h000 && !dma_req |=> !dma_req)
    else $error("issued over higher priority");
  chk_req_hold: assert property (dma_req && !dma_done |=> dma_req && $stable(mem_sel))
    else $error("request dropped early");
endmodule
bind host_slave_port host_slave_port_chk i_chk (.ref_clk(ref_clk), .reset(reset),
  .host_latch_enable_in(host_latch_enable_in), .host_write_strobe(host_write_strobe),
  .host_read_strobe(host_read_strobe), .host_memory_select(host_memory_select),
  .host_io_select(host_io_select), .host_ack_out(host_ack_out), .cfg_wr(cfg_wr),
  .reg_wdata(reg_wdata), .port_config_reg(port_config_reg), .peer_req(peer_req),
  .address_cycle_mode(address_cycle_mode), .dma_req(dma_req), .dma_cmd(dma_cmd),
  .dma_done(dma_done), .mem_sel(mem_sel), .core_steal(core_steal));

// ---- verif/host_model.sv ----
`timescale 1ns/1ps
module host_model (
  input  wire logic        ref_clk, // Paces the host.
  input  wire logic        ack_pol, // Active acknowledge level.
  input  wire logic        ack,     // Acknowledge pin.
  input  wire logic [15:0] bus,     // Resolved data wires.
  output logic [15:0]      ad = 16'h0000, // Host drive.
  output logic             ale = 1'b0,    // Address phase.
  output logic             wr = 1'b0,     // Write strobe.
  output logic             rd = 1'b0,     // Read strobe.
  output logic             msel = 1'b0,   // Memory select.
  output logic             iosel = 1'b0   // I/O select.
);
  // A released bus shows the inverse, so a stale value is never mistaken for data.
  task automatic release_bus();
    @(negedge ref_clk);
    {ale, wr, rd, msel, iosel} = 5'b00000;
    ad = ~ad;
    repeat (2) @(negedge ref_clk);
  endtask
  // Strobe stays up until acknowledge is seen at a rising edge, bounded.
  task automatic wait_ack(output logic ok, output logic [15:0] q);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== ack_pol && n < 300);
    ok = ack === ack_pol;
    q = bus;
    release_bus();
  endtask
  task automatic address(input logic io, acc, input logic [15:0] a, output logic ok);
    logic [15:0] q;
    @(negedge ref_clk);
    {msel, iosel} = {!io, io};
    {ale, wr, ad} = {1'b1, acc, a};
    ok = 1'b1;
    if (acc) wait_ack(ok, q);
    else release_bus();
  endtask
  task automatic data(input logic io, we, input logic [15:0] d, output logic ok,
                      output logic [15:0] q);
    @(negedge ref_clk);
    {msel, iosel, wr, rd} = {!io, io, we, !we};
    ad = we ? d : ~ad;
    wait_ack(ok, q);
  endtask
endmodule

// ---- verif/test_host_slave_port.sv ----
`timescale 1ns/1ps
module test_host_slave_port;
  import host_port_pkg::*;
  logic        ref_clk = 1'b0, reset = 1'b1, pol = 1'b0, strap = 1'b0; // Clock, straps.
  logic        cfg_wr = 1'b0, page_wr = 1'b0, done = 1'b0;            // Strobes.
  logic [7:0]  wdata = 8'h00, cfg;                                    // Registers.
  logic [9:0]  peer = 10'h000;                                        // Peer requests.
  logic [23:0] rdata = 24'h000000;                                    // DMA read data.
  logic [15:0] ad, ad_out, bus;                                       // Data wires.
  logic        ale, wr, rd, msel, iosel, ack, oe, dma_req, steal, acc_mode, last_steal;
  logic        ack_oe;                                                // Ack pin enable.
  logic [3:0]  sel, last_sel;                                         // Space selects.
  dma_cmd_type cmd, last_cmd;                                         // DMA accesses.
  logic [23:0] mem [0:255];                                           // Far memory.
  int          n_fail = 0, check_count = 0, n_issue = 0, n0, delay = 1;
  always #5 ref_clk = ~ref_clk;
  assign bus = oe ? ad_out : ad;
  host_slave_port i_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .host_ad_in(bus),
    .host_ad_out(ad_out), .host_ad_oe(oe), .host_latch_enable_in(ale), .host_write_strobe(wr),
    .host_read_strobe(rd), .host_memory_select(msel), .host_io_select(iosel),
    .ack_polarity_pin(pol), .host_ack_in(strap), .host_ack_out(ack), .host_ack_oe(ack_oe),
    .cfg_wr(cfg_wr), .page_wr(page_wr), .reg_wdata(wdata), .port_config_reg(cfg),
    .address_cycle_mode(acc_mode), .peer_req(peer), .dma_req(dma_req), .dma_cmd(cmd),
    .dma_done(done), .dma_rdata(rdata), .mem_sel(sel), .core_steal(steal));
  host_model i_host (.ref_clk(ref_clk), .ack_pol(pol), .ack(ack), .bus(bus), .ad(ad),
    .ale(ale), .wr(wr), .rd(rd), .msel(msel), .iosel(iosel));
  // DMA bus responder; read data is shown only with the done pulse.
  initial forever begin
    @(negedge ref_clk);
    if (dma_req === 1'b1) begin
      {last_cmd, last_sel, last_steal} = {cmd, sel, steal};
      n_issue++;
      repeat (delay) @(negedge ref_clk);
      if (last_cmd.we) mem[last_cmd.addr[7:0]] = last_cmd.data;
      {rdata, done} = {mem[last_cmd.addr[7:0]], 1'b1};
      @(negedge ref_clk);
      {rdata, done} = {~rdata, 1'b0};
    end
  end
  task automatic check(input logic [23:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic reset_dut(input logic p, s);
    @(negedge ref_clk);
    {reset, pol, strap} = {1'b1, p, s};
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic reg_write(input logic c, input logic [7:0] v);
    @(negedge ref_clk);
    {cfg_wr, page_wr, wdata} = {c, !c, v};
    @(negedge ref_clk);
    {cfg_wr, page_wr} = 2'b00;
  endtask
  // One address phase, then n units of v, lowest unit first.
  task automatic xfer(input logic we, io, acc, w16, input logic [15:0] a, input int n,
                      input logic [47:0] v);
    logic ok;
    logic [15:0] q, u;
    i_host.address(io, acc, a, ok);
    check(ok, 1'b1);
    check(acc_mode, acc);
    for (int k = 0; k < n; k++) begin
      u = w16 ? v[16*k +: 16] : {8'h00, v[8*k +: 8]};
      i_host.data(io, we, u, ok, q);
      check(ok, 1'b1);
      if (!we) check(w16 ? q : {8'h00, q[7:0]}, u);
    end
  endtask
  task automatic wait_issue();
    for (int t = 0; t < 200 && n_issue == n0; t++) @(negedge ref_clk);
    check(n_issue != n0, 1'b1);
  endtask
  initial begin
    foreach (mem[i]) mem[i] = {16'h5a5a, 8'(i)};
    for (int i = 3; i >= 0; i--) begin
      reset_dut(i[1], i[0]);
      check(cfg, {1'b0, i[1] == i[0], i[1], 5'h06});
      check(ack, !i[1]);
      check(ack_oe, 1'b1);
    end
    reg_write(1'b1, 8'hbe);
    check(cfg, 8'h9e);
    reg_write(1'b0, 8'h00);
    n0 = n_issue;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 16'h0010, 3, 48'h332211);
    wait_issue();
    check({last_cmd.addr[15:0], last_cmd.we, last_sel, last_steal}, 22'h000423);
    check(last_cmd.data, 24'h332211);
    delay = 12;
    xfer(1'b0, 1'b0, 1'b1, 1'b0, 16'h0010, 3, 48'h332211);
    repeat (40) @(negedge ref_clk);
    peer = 10'h200;
    n0 = n_issue;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 16'h9000, 3, 48'h665544);
    repeat (10) @(negedge ref_clk);
    check(n_issue, n0);
    peer = 10'h000;
    wait_issue();
    check({last_sel, last_steal}, 5'b00100);
    for (int j = 0; j < 2; j++) begin
      reg_write(1'b0, j ? 8'h80 : 8'h00);
      n0 = n_issue;
      xfer(1'b1, !j, 1'b1, 1'b0, 16'h0020, 3, 48'h998877);
      wait_issue();
      check(last_sel, j ? 4'b0100 : 4'b1000);
    end
    reg_write(1'b0, 8'h00);
    reg_write(1'b1, 8'h03);
    xfer(1'b1, 1'b0, 1'b0, 1'b1, 16'h0040, 1, 48'hbeef);
    xfer(1'b0, 1'b0, 1'b0, 1'b1, 16'h0040, 1, 48'hbeef);
    end_of_test;
  end
  // Watchdog well past the expected run of a few hundred cycles.
  initial begin
    #200us;
    n_fail++;
    end_of_test;
  end
endmodule
